/* shared/rail_cfg_pkg.sv */
// shared constants for the split-rail supply configuration link
package rail_cfg_pkg;
    // ----------------------------------------
    // bus addressing
    // ----------------------------------------
    localparam logic [6:0] SLAVE_ADDR      = 7'h3e;
    localparam logic [7:0] OFF_POS_LEVEL   = 8'h00;
    localparam logic [7:0] OFF_NEG_LEVEL   = 8'h01;
    localparam logic [7:0] OFF_RAIL_CTRL   = 8'h03;
    // ----------------------------------------
    // field positions and masks
    // ----------------------------------------
    localparam int         LEVEL_MSB       = 4;
    localparam int         BIT_APP_MODE    = 6;
    localparam int         BIT_SIM_SEQ     = 2;
    localparam int         BIT_POS_DIS     = 1;
    localparam int         BIT_NEG_DIS     = 0;
    localparam logic [7:0] LEVEL_WMASK     = 8'h1f;
    localparam logic [7:0] CTRL_WMASK      = 8'h47;
    // ----------------------------------------
    // factory defaults held in the nonvolatile store
    // ----------------------------------------
    localparam logic [7:0] RST_POS_LEVEL   = 8'h14;
    localparam logic [7:0] RST_NEG_LEVEL   = 8'h05;
    localparam logic [7:0] RST_RAIL_CTRL   = 8'h43;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int         CLK_MHZ         = 125;
    localparam int         PRELOAD_MAX_NS  = 20000;
    localparam int         PRELOAD_CYC     = PRELOAD_MAX_NS * CLK_MHZ / 1000;
    localparam int         NV_WORDS        = 3;
    localparam int         SCL_HALF_DIV    = 156;
    // ----------------------------------------
    // host command/status register map
    // ----------------------------------------
    localparam logic [1:0] HOST_REG_CMD    = 2'h0;
    localparam logic [1:0] HOST_REG_DATA   = 2'h1;
    localparam logic [1:0] HOST_REG_STAT   = 2'h2;
    localparam int         CMD_GO_BIT      = 0;
    localparam int         CMD_RD_BIT      = 1;
    localparam int         CMD_CUR_BIT     = 2;
endpackage

/* shared/rail_i2c_if.sv */
// two-wire bus between the controller and the supply device
`timescale 1ns/1ps
`default_nettype none
interface rail_i2c_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_oe;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_host_o;
    logic scl;
    logic sda;
    // open drain with pull-ups: any enabled driver pulls low
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
    modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

/* verilog/rail_cfg_dev.sv */
// supply device end: bus slave, setting registers, rail enable and discharge logic
// Function
// - enabled when supply ok and any enable high
// - low enable disables its rail only, outside simultaneous mode
// - slave only, same protocol both rates
// - address 0111110, last bit direction
// - start/stop are sda edges with scl high
// - acknowledge only own address, ninth clock
// - receiver acks every byte, unlimited bytes
// - after stop ignore until start and address
// - read pointer increments after each byte
// - preload nonvolatile values within 20 us
// - store and settings share addresses; here the store is 3 words with control at index 2
// - 0x00 positive code in bits 4..0
// - 0x01 negative code in bits 4..0
// - 0x03 mode, sequencing, discharge bits
// - reserved bits ignore writes
// - undefined addresses read zero
// - defaults 0x14, 0x05, 0x43
// - simultaneous mode ties both rails
// - positive discharge by supply and enables
// - negative discharge by supply and enables
`timescale 1ns/1ps
`default_nettype none
module rail_cfg_dev
    import rail_cfg_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  reset_n_i,
    rail_i2c_if.dev    bus,
    input  wire logic  pos_rail_enable_i,
    input  wire logic  neg_rail_enable_i,
    input  wire logic  supply_above_uv_i,
    output logic       device_on_o,
    output logic       pos_rail_on_o,
    output logic       neg_rail_on_o,
    output logic       pos_discharge_o,
    output logic       neg_discharge_o,
    output logic [4:0] pos_level_code_o,
    output logic [4:0] neg_level_code_o,
    output logic       application_mode_sel_o,
    output logic       preload_done_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WR   = 3'b011,
        S_WACK = 3'b100,
        S_RD   = 3'b101,
        S_RACK = 3'b110
    } slv_state_t;

    typedef struct packed {
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic        scl_d;
        logic        sda_d;
        logic [1:0]  pins_m;
        logic [1:0]  pins_s;
        logic        uv_s1;
        logic        uv_s2;
        slv_state_t  st;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic [7:0]  ptr;
        logic        have_ptr;
        logic        rd_dir;
        logic        sda_oe;
        logic [7:0]  pos_reg;
        logic [7:0]  neg_reg;
        logic [7:0]  ctl_reg;
        logic [15:0] pl_cnt;
        logic [1:0]  pl_idx;
        logic        pl_done;
        logic        dev_on;
        logic        pos_on;
        logic        neg_on;
        logic        pos_dis;
        logic        neg_dis;
    } dev_state_t;

    dev_state_t s_r, s_nxt;

    // nonvolatile init store, words 0..2 loaded into the settings at 0x00, 0x01 and 0x03
    localparam logic [7:0] NV_IMAGE [NV_WORDS] = '{RST_POS_LEVEL, RST_NEG_LEVEL, RST_RAIL_CTRL};

    function automatic logic [7:0] reg_read(input logic [7:0] a, input dev_state_t st);
        case (a)
            OFF_POS_LEVEL: reg_read = st.pos_reg & LEVEL_WMASK;
            OFF_NEG_LEVEL: reg_read = st.neg_reg & LEVEL_WMASK;
            OFF_RAIL_CTRL: reg_read = st.ctl_reg & CTRL_WMASK;
            default:       reg_read = 8'h00;
        endcase
    endfunction

    logic sda_rise_hi;
    logic sda_fall_hi;
    logic scl_rise;
    logic scl_fall;
    logic pos_en;
    logic neg_en;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // two-flop synchronisers; the first stage feeds no logic
        s_nxt.scl_s  = {s_r.scl_s[0], bus.scl};
        s_nxt.sda_s  = {s_r.sda_s[0], bus.sda};
        s_nxt.scl_d  = s_r.scl_s[1];
        s_nxt.sda_d  = s_r.sda_s[1];
        s_nxt.pins_m = {pos_rail_enable_i, neg_rail_enable_i};
        s_nxt.pins_s = s_r.pins_m;
        s_nxt.uv_s1  = supply_above_uv_i;
        s_nxt.uv_s2  = s_r.uv_s1;
        sda_fall_hi  = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
        sda_rise_hi  = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];
        scl_rise     = s_r.scl_s[1] & ~s_r.scl_d;
        scl_fall     = ~s_r.scl_s[1] & s_r.scl_d;

        // preload: one store word per cycle, well inside the allowed time
        if (!s_r.pl_done) begin
            s_nxt.pl_cnt = s_r.pl_cnt + 16'h0001;
            case (s_r.pl_idx)
                2'h0:    s_nxt.pos_reg = NV_IMAGE[0];
                2'h1:    s_nxt.neg_reg = NV_IMAGE[1];
                default: s_nxt.ctl_reg = NV_IMAGE[2];
            endcase
            s_nxt.pl_idx = s_r.pl_idx + 2'h1;
            if (s_r.pl_idx == 2'(NV_WORDS - 1) || s_r.pl_cnt == 16'(PRELOAD_CYC - 1)) begin
                s_nxt.pl_done = 1'b1;
            end
        end

        // slave engine (scl is oversampled, so rate does not matter)
        if (sda_fall_hi) begin
            s_nxt.st     = S_ADDR;
            s_nxt.bitcnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end else if (sda_rise_hi) begin
            s_nxt.st     = S_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (s_r.pl_done) begin
            case (s_r.st)
                S_IDLE: s_nxt.sda_oe = 1'b0;
                S_ADDR, S_WR: begin
                    if (scl_rise) begin
                        s_nxt.shreg  = {s_r.shreg[6:0], s_r.sda_d};
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    end
                    if (scl_fall && s_r.bitcnt == 4'h8) begin
                        s_nxt.bitcnt = 4'h0;
                        if (s_r.st == S_ADDR) begin
                            if (s_r.shreg[7:1] == SLAVE_ADDR) begin
                                s_nxt.sda_oe   = 1'b1;
                                s_nxt.rd_dir   = s_r.shreg[0];
                                s_nxt.have_ptr = 1'b0;
                                s_nxt.st       = S_AACK;
                            end else begin
                                s_nxt.st = S_IDLE;
                            end
                        end else begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.st     = S_WACK;
                            if (!s_r.have_ptr) begin
                                s_nxt.ptr      = s_r.shreg;
                                s_nxt.have_ptr = 1'b1;
                            end else begin
                                // reserved bits are written as zero
                                case (s_r.ptr)
                                    OFF_POS_LEVEL: s_nxt.pos_reg = s_r.shreg & LEVEL_WMASK;
                                    OFF_NEG_LEVEL: s_nxt.neg_reg = s_r.shreg & LEVEL_WMASK;
                                    OFF_RAIL_CTRL: s_nxt.ctl_reg = s_r.shreg & CTRL_WMASK;
                                    default:       s_nxt.ctl_reg = s_r.ctl_reg;
                                endcase
                                s_nxt.ptr = s_r.ptr + 8'h01;
                            end
                        end
                    end
                end
                S_AACK, S_WACK: begin
                    if (scl_fall) begin
                        if (s_r.rd_dir) begin
                            s_nxt.shreg  = reg_read(s_r.ptr, s_r);
                            s_nxt.sda_oe = ~reg_read(s_r.ptr, s_r) >> 7 == 8'h01;
                            s_nxt.st     = S_RD;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = S_WR;
                        end
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                        if (s_r.bitcnt == 4'h7) begin
                            s_nxt.sda_oe = 1'b0; // master acks
                            s_nxt.bitcnt = 4'h0;
                            s_nxt.ptr    = s_r.ptr + 8'h01;
                            s_nxt.st     = S_RACK;
                        end else begin
                            s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shreg[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise && s_r.sda_d) begin
                        s_nxt.st = S_IDLE; // nack ends the read
                    end else if (scl_fall) begin
                        s_nxt.shreg  = reg_read(s_r.ptr, s_r);
                        s_nxt.sda_oe = ~reg_read(s_r.ptr, s_r) >> 7 == 8'h01;
                        s_nxt.st     = S_RD;
                    end
                end
                default: s_nxt.st = S_IDLE;
            endcase
        end

        // rail enables and discharge
        pos_en = s_r.pins_s[1];
        neg_en = s_r.pins_s[0];
        if (s_r.ctl_reg[BIT_SIM_SEQ]) begin
            pos_en = s_r.pins_s[1] | s_r.pins_s[0];
            neg_en = pos_en;
        end
        s_nxt.dev_on = s_r.uv_s2 & (s_r.pins_s[1] | s_r.pins_s[0]) & s_r.pl_done;
        s_nxt.pos_on = s_nxt.dev_on & pos_en;
        s_nxt.neg_on = s_nxt.dev_on & neg_en;
        if (!s_r.uv_s2 || s_r.pins_s == 2'b00) begin
            s_nxt.pos_dis = 1'b1;
            s_nxt.neg_dis = 1'b1;
        end else begin
            s_nxt.pos_dis = (s_r.pins_s == 2'b01) & s_r.ctl_reg[BIT_POS_DIS];
            s_nxt.neg_dis = (s_r.pins_s == 2'b10) & s_r.ctl_reg[BIT_NEG_DIS];
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r        <= '0;
            s_r.scl_s  <= 2'h3;
            s_r.sda_s  <= 2'h3;
            s_r.scl_d  <= 1'b1;
            s_r.sda_d  <= 1'b1;
            s_r.st     <= S_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // sda driven low only: output value fixed at zero, enable carries the bit
    assign bus.sda_dev_o          = 1'b0;
    assign bus.sda_dev_oe         = s_r.sda_oe;
    assign device_on_o            = s_r.dev_on;
    assign pos_rail_on_o          = s_r.pos_on;
    assign neg_rail_on_o          = s_r.neg_on;
    assign pos_discharge_o        = s_r.pos_dis;
    assign neg_discharge_o        = s_r.neg_dis;
    assign pos_level_code_o       = s_r.pos_reg[LEVEL_MSB:0];
    assign neg_level_code_o       = s_r.neg_reg[LEVEL_MSB:0];
    assign application_mode_sel_o = s_r.ctl_reg[BIT_APP_MODE];
    assign preload_done_o         = s_r.pl_done;
endmodule
`default_nettype wire

/* verilog/rail_cfg_host.sv */
// controller end: bus master doing one-register write, pointer-then-read or current-address read
`timescale 1ns/1ps
`default_nettype none
module rail_cfg_host
    import rail_cfg_pkg::*;
#(
    parameter int HALF_DIV = SCL_HALF_DIV
)(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    rail_i2c_if.host        bus,
    input  wire logic [1:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [15:0]     rdata_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_BIT   = 3'b010,
        H_STOP  = 3'b011,
        H_RSTRT = 3'b100
    } host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [1:0]  sda_s;
        logic [8:0]  div;
        logic [1:0]  ph;
        logic [3:0]  bitn;
        logic [2:0]  byten;
        logic [8:0]  sh;
        logic [7:0]  reg_addr;
        logic [7:0]  wdat;
        logic [7:0]  rdat;
        logic        is_rd;
        logic        nack;
        logic        scl_lo;
        logic        sda_lo;
        logic [15:0] rdata;
    } host_state_s_t;

    host_state_s_t h_r, h_nxt;
    logic          tick;

    // ----------------------------------------
    // master sequencer: each bit is four quarter-periods
    // ----------------------------------------
    always_comb begin
        h_nxt       = h_r;
        h_nxt.sda_s = {h_r.sda_s[0], bus.sda};
        tick        = (h_r.div == 9'(HALF_DIV / 2 - 1));
        h_nxt.div   = tick ? 9'h000 : h_r.div + 9'h001;
        h_nxt.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                HOST_REG_DATA: h_nxt.rdata = {8'h00, h_r.rdat};
                HOST_REG_STAT: h_nxt.rdata = {14'h0000, h_r.nack, h_r.st != H_IDLE};
                default:       h_nxt.rdata = {8'h00, h_r.reg_addr};
            endcase
        end
        if (wr_i && addr_i == HOST_REG_DATA) begin
            h_nxt.wdat = wdata_i[7:0];
        end
        case (h_r.st)
            H_IDLE: begin
                h_nxt.scl_lo = 1'b0;
                h_nxt.sda_lo = 1'b0;
                if (wr_i && addr_i == HOST_REG_CMD && wdata_i[CMD_GO_BIT]) begin
                    h_nxt.reg_addr = wdata_i[15:8];
                    h_nxt.is_rd    = wdata_i[CMD_RD_BIT];
                    h_nxt.nack     = 1'b0;
                    h_nxt.ph       = 2'h0;
                    // a current-address read skips the pointer and starts at the read address byte
                    h_nxt.byten    = wdata_i[CMD_CUR_BIT] ? 3'h2 : 3'h0;
                    h_nxt.st       = H_START;
                end
            end
            H_START, H_RSTRT: if (tick) begin
                h_nxt.ph = h_r.ph + 2'h1;
                case (h_r.ph)
                    2'h0:    begin h_nxt.sda_lo = 1'b0; h_nxt.scl_lo = 1'b0; end
                    2'h1:    h_nxt.sda_lo = 1'b1;
                    2'h2:    h_nxt.scl_lo = 1'b1;
                    default: begin
                        h_nxt.bitn = 4'h0;
                        h_nxt.ph   = 2'h0;
                        h_nxt.sh   = {SLAVE_ADDR, h_r.byten == 3'h2, 1'b1}; // read once the pointer is sent or skipped
                        h_nxt.st   = H_BIT;
                    end
                endcase
            end
            H_BIT: if (tick) begin
                h_nxt.ph = h_r.ph + 2'h1;
                case (h_r.ph)
                    2'h0:    h_nxt.sda_lo = ~h_r.sh[8];
                    2'h1:    h_nxt.scl_lo = 1'b0;
                    2'h2: begin
                        h_nxt.sh = {h_r.sh[7:0], h_r.sda_s[1]};
                        if (h_r.bitn == 4'h8 && h_r.sda_s[1] && !(h_r.byten == 3'h3)) begin
                            h_nxt.nack = 1'b1;
                        end
                    end
                    default: begin
                        h_nxt.scl_lo = 1'b1;
                        h_nxt.bitn   = h_r.bitn + 4'h1;
                        if (h_r.bitn == 4'h8) begin
                            h_nxt.bitn  = 4'h0;
                            h_nxt.byten = h_r.byten + 3'h1;
                            if (h_r.byten == 3'h3) h_nxt.rdat = h_r.sh[8:1];
                            if (h_r.nack || h_r.byten == 3'h3 || (h_r.byten == 3'h2 && !h_r.is_rd)) begin
                                h_nxt.st = H_STOP;
                            end else if (h_r.byten == 3'h1 && h_r.is_rd) begin
                                h_nxt.st = H_RSTRT;
                            end else if (h_r.byten == 3'h0) begin
                                h_nxt.sh = {h_r.reg_addr, 1'b1};
                            end else if (h_r.byten == 3'h1) begin
                                h_nxt.sh = {h_r.wdat, 1'b1};
                            end else begin
                                h_nxt.sh = 9'h1ff; // read byte: release, then nack
                            end
                            if (h_r.byten == 3'h2 && h_r.is_rd) h_nxt.sh = 9'h1ff;
                        end
                    end
                endcase
            end
            H_STOP: if (tick) begin
                h_nxt.ph = h_r.ph + 2'h1;
                case (h_r.ph)
                    2'h0:    h_nxt.sda_lo = 1'b1;
                    2'h1:    h_nxt.scl_lo = 1'b0;
                    2'h2:    h_nxt.sda_lo = 1'b0;
                    default: h_nxt.st = H_IDLE;
                endcase
            end
            default: h_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            h_r       <= '0;
            h_r.sda_s <= 2'h3;
            h_r.st    <= H_IDLE;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign bus.scl_o       = 1'b0;
    assign bus.scl_oe      = h_r.scl_lo;
    assign bus.sda_host_o  = 1'b0;
    assign bus.sda_host_oe = h_r.sda_lo;
    assign rdata_o         = h_r.rdata;
endmodule
`default_nettype wire

/* sim/rail_i2c_chk.sv */
// checker for the two-wire link between the controller and the supply device
`timescale 1ns/1ps
`default_nettype none
module rail_i2c_chk
    import rail_cfg_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic sda_dev_oe,
    input  wire logic sda_host_oe
);
    logic       scl_r, sda_r, addr_ph_r, rw_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    wire        rise  = scl & ~scl_r;
    wire        start = scl & scl_r & sda_r & ~sda;
    wire        stop  = scl & scl_r & ~sda_r & sda;
    wire        ninth = rise & (cnt_r == 4'h8);
    // bit count restarts at every start, so a repeated start re-enters the address byte
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {scl_r, sda_r, addr_ph_r, rw_r, cnt_r, sh_r} <= {4'b1100, 4'h0, 8'h00};
        end else begin
            scl_r <= scl;
            sda_r <= sda;
            if (start) begin
                cnt_r     <= 4'h0;
                addr_ph_r <= 1'b1;
            end else if (rise) begin
                cnt_r <= ninth ? 4'h0 : cnt_r + 4'h1;
                if (!ninth) sh_r <= {sh_r[6:0], sda};
                if (ninth) addr_ph_r <= 1'b0;
                // a master nack ends the read, so the clock before the stop is not read data
                if (ninth) rw_r <= addr_ph_r ? sh_r[0] : (rw_r & ~sda);
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // acknowledge is held for eight clocks from the rise of the ninth clock
    sequence ack_held;
        (sda_dev_oe && !sda) [*8];
    endsequence
    sequence dev_released;
        (!sda_dev_oe) [*8];
    endsequence
    hold_high_a: assert property (scl && scl_r |-> $stable(sda_dev_oe))
        else $error("device sda moved with scl high");
    addr_ack_a: assert property (ninth && addr_ph_r && sh_r[7:1] == SLAVE_ADDR |-> ack_held)
        else $error("own address not acked");
    addr_quiet_a: assert property (rise && addr_ph_r && cnt_r < 4'h8 |-> !sda_dev_oe)
        else $error("device drove during address");
    stop_free_a: assert property (stop |-> ##1 dev_released)
        else $error("device held sda after stop");
    start_host_a: assert property (start |-> !sda_dev_oe && sda_host_oe)
        else $error("start not made by controller");
    wdata_ack_a: assert property (ninth && !addr_ph_r && !rw_r |-> ack_held)
        else $error("written byte not acked");
    mack_free_a: assert property (ninth && !addr_ph_r && rw_r |-> !sda_dev_oe)
        else $error("device drove master ack bit");
    host_quiet_a: assert property (rise && !addr_ph_r && rw_r && cnt_r < 4'h8 |-> !sda_host_oe)
        else $error("controller drove read data bit");
endmodule
`default_nettype wire

/* sim/test_dual_rail_i2c_config.sv */
// bench: controller and device joined over the link, driven and watched
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t %0h %0h", $time, a, e); end end
module test_dual_rail_i2c_config
    import rail_cfg_pkg::*;
;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        uv = 1'b1, pos_en = 1'b0, neg_en = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [4:0]  pos_code, neg_code;
    logic        dev_on, pos_on, neg_on, pos_dis, neg_dis, app_mode, pre_done;
    logic [7:0]  shadow [256];
    int          n_mismatch = 0, checks = 0, seed = 61256;
    rail_i2c_if bus_if ();
    rail_cfg_dev rail_cfg_dev_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus_if.dev), .pos_rail_enable_i(pos_en),
        .neg_rail_enable_i(neg_en), .supply_above_uv_i(uv), .device_on_o(dev_on), .pos_rail_on_o(pos_on),
        .neg_rail_on_o(neg_on), .pos_discharge_o(pos_dis), .neg_discharge_o(neg_dis), .pos_level_code_o(pos_code),
        .neg_level_code_o(neg_code), .application_mode_sel_o(app_mode), .preload_done_o(pre_done));
    // short bit time keeps the run small; the protocol itself does not depend on it
    rail_cfg_host #(.HALF_DIV(16)) rail_cfg_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus_if.host),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    rail_i2c_chk rail_i2c_chk_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl(bus_if.scl), .sda(bus_if.sda),
        .sda_dev_oe(bus_if.sda_dev_oe), .sda_host_oe(bus_if.sda_host_oe));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask
    // one register access over the link; rdn bit0 read, bit1 current-address read; busy polled under a bound
    task automatic xfer(input logic [7:0] p, input logic [1:0] rdn, input logic [7:0] v, output logic [7:0] d);
        logic [15:0] s;
        if (!rdn) bus_wr(HOST_REG_DATA, {8'h00, v});
        bus_wr(HOST_REG_CMD, {p, 5'h00, rdn, 1'b1});
        s = 16'h0001;
        for (int k = 0; k < 3000 && s[0] !== 1'b0; k++) bus_rd(HOST_REG_STAT, s);
        `CHK(s[1:0], 2'b00)
        bus_rd(HOST_REG_CMD, s);
        `CHK(s, {8'h00, p})
        bus_rd(HOST_REG_DATA, s);
        d = s[7:0];
    endtask
    // write, read back through a repeated start, compare with the masked value
    task automatic wr_chk(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] d;
        xfer(p, 1'b0, v, d);
        shadow[p] = v & ((p == OFF_RAIL_CTRL) ? CTRL_WMASK : (p <= OFF_NEG_LEVEL) ? LEVEL_WMASK : 8'h00);
        // the pointer has moved past the written byte
        xfer(8'h00, 2'b11, 8'h00, d);
        `CHK(d, shadow[8'(p + 8'h01)])
        xfer(p, 1'b1, 8'h00, d);
        `CHK(d, shadow[p])
        // and past the byte just read
        xfer(8'h00, 2'b11, 8'h00, d);
        `CHK(d, shadow[8'(p + 8'h01)])
        `CHK({app_mode, neg_code, pos_code}, {shadow[3][BIT_APP_MODE], shadow[1][4:0], shadow[0][4:0]})
    endtask
    // expected {on, pos on, neg on, pos discharge, neg discharge} for pins {supply ok, pos, neg}
    function automatic logic [4:0] rails(input logic [2:0] pin, input logic [7:0] c);
        logic any;
        any = pin[1] | pin[0];
        return {pin[2] & any, pin[2] & (c[BIT_SIM_SEQ] ? any : pin[1]), pin[2] & (c[BIT_SIM_SEQ] ? any : pin[0]),
            ~pin[2] | ~any | (~pin[1] & c[BIT_POS_DIS]), ~pin[2] | ~any | (~pin[0] & c[BIT_NEG_DIS])};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence: preload, defaults, random writes, then the enable matrix
    initial begin
        logic [7:0] d, v;
        logic [4:0] e;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[0] = RST_POS_LEVEL;
        shadow[1] = RST_NEG_LEVEL;
        shadow[3] = RST_RAIL_CTRL;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (PRELOAD_CYC) @(negedge clk_i);
        `CHK(pre_done, 1'b1)
        `CHK({app_mode, neg_code, pos_code}, {RST_RAIL_CTRL[6], RST_NEG_LEVEL[4:0], RST_POS_LEVEL[4:0]})
        @(posedge clk_i);
        // both enables are low here: the device is off yet the link must answer
        for (int p = 0; p < 5; p++) begin
            xfer(8'(p), 1'b1, 8'h00, d);
            `CHK(d, shadow[p])
        end
        for (int k = 0; k < 8; k++) begin
            v = 8'($random(seed));
            wr_chk(k < 4 ? 8'(k) : 8'($random(seed)), k == 0 ? 8'hff : v);
        end
        for (int i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            if (i % 8 == 0) wr_chk(OFF_RAIL_CTRL, {v[7:3], i[3], v[1:0]});
            {uv, pos_en, neg_en} <= i[2:0];
            repeat (8) @(posedge clk_i);
            @(negedge clk_i);
            e = rails(i[2:0], shadow[3]);
            `CHK({dev_on, pos_on, neg_on}, e[4:2])
            `CHK({pos_dis, neg_dis}, e[1:0])
            @(posedge clk_i);
        end
        final_report();
    end
    // watchdog: the tests take well under this span
    initial begin
        #(90000 * 8);
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
